// ===== hw/ffr_map.svh
/*
 fault flag response block: register offsets, flag bit positions,
 reset values and timing counts.
 assumes a 50 MHz clock; included by bare name.
*/
`ifndef FFR_MAP_SVH
`define FFR_MAP_SVH

// ****************************************
// register byte offsets
// ****************************************
`define FFR_ADR_FLAG 8'h00
`define FFR_ADR_MASK 8'h04
`define FFR_ADR_STAT 8'h08
`define FFR_ADR_CTRL 8'h0c

// ****************************************
// flag bit positions
// ****************************************
`define FFR_NFLAG 15
`define FFR_B_PGOOD 0
`define FFR_B_OVP 1
`define FFR_B_OCP 2
`define FFR_B_UVLO 3
`define FFR_B_COLD 4
`define FFR_B_COOL 5
`define FFR_B_WARM 6
`define FFR_B_HOT 7
`define FFR_B_OPEN 8
`define FFR_B_ADC 9
`define FFR_B_WD 10
`define FFR_B_TMR 11
`define FFR_B_WAKE1 12
`define FFR_B_WAKE2 13
`define FFR_B_WARN 14
`define FFR_B_DOUBLE 0

// ****************************************
// reset values
// ****************************************
`define FFR_FLAG_RST 15'h0000
`define FFR_MASK_RST 15'h0000
`define FFR_CTRL_RST 1'h0

// ****************************************
// timing
// ****************************************
`define FFR_CLK_KHZ 50000
`define FFR_INT_PULSE_US 128
`define FFR_INT_PULSE_CYC ((`FFR_INT_PULSE_US * `FFR_CLK_KHZ + 999) / 1000)
`define FFR_WAKE1_MS 100
`define FFR_WAKE2_MS 1000
`define FFR_WARN_MS 5000
`define FFR_WAKE1_CYC (`FFR_WAKE1_MS * `FFR_CLK_KHZ)
`define FFR_WAKE2_CYC (`FFR_WAKE2_MS * `FFR_CLK_KHZ)
`define FFR_WARN_CYC (`FFR_WARN_MS * `FFR_CLK_KHZ)

`endif

// ===== hw/ffr_pkg.sv
/*
 fault flag response block: shared types.
 assumes ffr_map.svh for the widths it uses.
*/
`include "ffr_map.svh"
package ffr_pkg;
   // one bit per flag
   typedef logic [`FFR_NFLAG-1:0] ffr_flags_t;
   // push-button hold counter
   typedef logic [31:0] ffr_count_t;
endpackage

// ===== hw/ffr_press_timer.sv
/*
 push-button hold timer: reports how long the button has been held low.
 assumes a synchronous, debounced active-low button level.
*/
`timescale 1ns/1ps
`include "ffr_map.svh"
module ffr_press_timer
#(
   parameter int P_WAKE1_CYC = `FFR_WAKE1_CYC,
   parameter int P_WAKE2_CYC = `FFR_WAKE2_CYC,
   parameter int P_WARN_CYC = `FFR_WARN_CYC
)
(
   input wire logic clk_i, // system clock
   input wire logic rst_i, // sync reset, high
   input wire logic push_button_input_n_i, // button, low = held
   output logic wake1_o, // held past first wake time
   output logic wake2_o, // held past second wake time
   output logic warn_o // held past reset-warning time
);

   ffr_pkg::ffr_count_t cnt_q, cnt_d;
   logic wake1_q, wake1_d, wake2_q, wake2_d, warn_q, warn_d;

   // count held cycles, saturate at the longest time
   always_comb
   begin
      cnt_d = cnt_q;
      if (push_button_input_n_i)
         cnt_d = '0;
      else if (cnt_q < ffr_pkg::ffr_count_t'(P_WARN_CYC))
         cnt_d = cnt_q + 32'h1;
      wake1_d = cnt_d >= ffr_pkg::ffr_count_t'(P_WAKE1_CYC);
      wake2_d = cnt_d >= ffr_pkg::ffr_count_t'(P_WAKE2_CYC);
      warn_d = cnt_d >= ffr_pkg::ffr_count_t'(P_WARN_CYC);
   end

   // register count and levels
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cnt_q <= '0;
         wake1_q <= 1'b0;
         wake2_q <= 1'b0;
         warn_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         wake1_q <= wake1_d;
         wake2_q <= wake2_d;
         warn_q <= warn_d;
      end
   end

   assign wake1_o = wake1_q;
   assign wake2_o = wake2_q;
   assign warn_o = warn_q;

endmodule

// ===== hw/ffr_top.sv
/*
 fault and status flag response of a single-cell charger, with a
 classic wishbone register slave, sticky flags, mask and interrupt.
 assumes all condition inputs are synchronous levels or one-cycle
 pulses from the charger, thermistor comparators, converter and timers.
*/
// Decided for this implementation: the Wishbone register port and the register addresses.
// Behaviour
// - power-good low disables charging; any power-good change resets safety timer
// - overvoltage sets flag, pauses charging, resets timer, rail fed from battery
// - battery overcurrent on battery only: flag, charging off, battery disconnected
// - battery undervoltage sets flag; charging and timer left alone
// - cold sets flag and pauses charging and timer
// - cool sets flag, cuts current, doubles timer when option set
// - warm sets flag, lowers regulation voltage, timer unaffected
// - hot sets flag and pauses charging and timer
// - open thermistor sets flag and pauses charging and timer
// - each finished conversion sets converter-ready flag, nothing else
// - bus watchdog expiry sets its flag, charging stays enabled
// - timer expiry latches fault until supply or enable toggle; timer restarts after
// - button held past first wake time sets first wake flag
// - button held past second wake time sets second wake flag
// - button held past warning time sets reset-warning flag
// - unmasked event gives one low interrupt pulse; masked event never does
`timescale 1ns/1ps
`include "ffr_map.svh"
module ffr_top
#(
   parameter int P_INT_PULSE_CYC = `FFR_INT_PULSE_CYC,
   parameter int P_WAKE1_CYC = `FFR_WAKE1_CYC,
   parameter int P_WAKE2_CYC = `FFR_WAKE2_CYC,
   parameter int P_WARN_CYC = `FFR_WARN_CYC
)
(
   input wire logic clk_i, // system clock
   input wire logic rst_i, // sync reset, high
   input wire logic wb_cyc_i, // bus cycle
   input wire logic wb_stb_i, // strobe
   input wire logic wb_we_i, // write
   input wire logic [7:0] wb_adr_i, // byte address
   input wire logic [3:0] wb_sel_i, // byte lanes
   input wire logic [31:0] wb_dat_i, // write data
   output logic [31:0] wb_dat_o, // read data
   output logic wb_ack_o, // acknowledge
   output logic irq_o, // level, unmasked flag set
   input wire logic input_power_good_status_i, // input supply good
   input wire logic input_overvoltage_i, // input over threshold
   input wire logic bat_overcurrent_i, // discharge over limit
   input wire logic bat_only_i, // running from battery only
   input wire logic bat_undervoltage_i, // battery under lockout
   input wire logic therm_cold_i, // above cold threshold
   input wire logic therm_cool_i, // between cool and cold
   input wire logic therm_warm_i, // between hot and warm
   input wire logic therm_hot_i, // below hot threshold
   input wire logic therm_open_i, // above open threshold
   input wire logic adc_done_i, // conversion done pulse
   input wire logic bus_watchdog_expired_i, // watchdog expiry pulse
   input wire logic charge_timer_expired_i, // safety timer expiry pulse
   input wire logic charge_enable_i, // charge enable level
   input wire logic push_button_input_n_i, // button, low = held
   output logic charge_enable_o, // charging allowed
   output logic charge_paused_o, // charging paused
   output logic charge_current_reduced_o, // reduced current
   output logic reg_voltage_reduced_o, // lowered regulation voltage
   output logic timer_reset_o, // safety timer reset pulse
   output logic timer_pause_o, // safety timer held
   output logic timer_double_o, // safety timer doubled
   output logic system_rail_from_battery_o, // rail fed by battery
   output logic battery_disconnect_o, // battery off the rail
   output logic int_n_o, // interrupt pin level when driven
   output logic int_oe_o // interrupt pin driven low
);

   // ****************************************
   // declarations
   // ****************************************
   ffr_pkg::ffr_flags_t cond, ev, flag_q, flag_d, prev_q, w1c;
   ffr_pkg::ffr_flags_t mask_q, mask_d;
   logic ctrl_q, ctrl_d;
   logic ack_q, ack_d;
   logic [31:0] dat_q, dat_d;
   logic req, wr;
   logic [31:0] w1c_m, mask_m, ctrl_m;
   logic wake1, wake2, warn;
   logic tfault_q, tfault_d, ce_prev_q, toggle;
   logic start;
   logic [15:0] icnt_q, icnt_d;
   logic ioe_q, ioe_d;
   logic chg_en_q, chg_en_d, paused_q, paused_d;
   logic cur_red_q, cur_red_d, vreg_red_q, vreg_red_d;
   logic trst_q, trst_d, tpause_q, tpause_d, tdbl_q, tdbl_d;
   logic rail_bat_q, rail_bat_d, bat_disc_q, bat_disc_d;

   // byte-lane merge for writes and clears
   function automatic logic [31:0] ffr_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
            r[i*8 +: 8] = new_v[i*8 +: 8];
      end
      return r;
   endfunction

   // ****************************************
   // push-button hold timer
   // ****************************************
   ffr_press_timer
   #(
      .P_WAKE1_CYC(P_WAKE1_CYC),
      .P_WAKE2_CYC(P_WAKE2_CYC),
      .P_WARN_CYC(P_WARN_CYC)
   )
   u_press
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .push_button_input_n_i(push_button_input_n_i),
      .wake1_o(wake1),
      .wake2_o(wake2),
      .warn_o(warn)
   );

   // ****************************************
   // conditions and edges
   // ****************************************
   // live condition vector, also readable as status
   always_comb
   begin
      cond = '0;
      cond[`FFR_B_PGOOD] = input_power_good_status_i;
      cond[`FFR_B_OVP] = input_overvoltage_i;
      cond[`FFR_B_OCP] = bat_overcurrent_i & bat_only_i;
      cond[`FFR_B_UVLO] = bat_undervoltage_i;
      cond[`FFR_B_COLD] = therm_cold_i;
      cond[`FFR_B_COOL] = therm_cool_i;
      cond[`FFR_B_WARM] = therm_warm_i;
      cond[`FFR_B_HOT] = therm_hot_i;
      cond[`FFR_B_OPEN] = therm_open_i;
      cond[`FFR_B_ADC] = adc_done_i;
      cond[`FFR_B_WD] = bus_watchdog_expired_i;
      cond[`FFR_B_TMR] = tfault_q;
      cond[`FFR_B_WAKE1] = wake1;
      cond[`FFR_B_WAKE2] = wake2;
      cond[`FFR_B_WARN] = warn;
   end

   always_comb
   begin
      ev = cond & ~prev_q;
      ev[`FFR_B_PGOOD] = cond[`FFR_B_PGOOD] ^ prev_q[`FFR_B_PGOOD];
   end

   // supply or enable coming back counts as a toggle
   assign toggle = (ev[`FFR_B_PGOOD] & input_power_good_status_i)
                   | (charge_enable_i & ~ce_prev_q);

   // fault latch, expiry beats a toggle
   always_comb
   begin
      tfault_d = charge_timer_expired_i | (tfault_q & ~toggle);
   end

   // register edge history and fault latch
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         prev_q <= `FFR_FLAG_RST;
         ce_prev_q <= 1'b0;
         tfault_q <= 1'b0;
      end
      else
      begin
         prev_q <= cond;
         ce_prev_q <= charge_enable_i;
         tfault_q <= tfault_d;
      end
   end

   // ****************************************
   // wishbone slave
   // ****************************************
   assign req = wb_cyc_i & wb_stb_i & ~ack_q;
   // writes land on the edge that sees ack, where the master commits them
   assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;

   // decode; unmapped reads give zero and are still acked
   always_comb
   begin
      ack_d = req;
      dat_d = dat_q;
      mask_d = mask_q;
      ctrl_d = ctrl_q;
      w1c = '0;
      w1c_m = ffr_merge(32'h0, wb_dat_i, wb_sel_i);
      mask_m = ffr_merge({17'h0, mask_q}, wb_dat_i, wb_sel_i);
      ctrl_m = ffr_merge({31'h0, ctrl_q}, wb_dat_i, wb_sel_i);
      if (req & ~wb_we_i)
      begin
         dat_d = '0;
         if (wb_adr_i == `FFR_ADR_FLAG)
            dat_d[`FFR_NFLAG-1:0] = flag_q;
         else if (wb_adr_i == `FFR_ADR_MASK)
            dat_d[`FFR_NFLAG-1:0] = mask_q;
         else if (wb_adr_i == `FFR_ADR_STAT)
            dat_d[`FFR_NFLAG-1:0] = cond;
         else if (wb_adr_i == `FFR_ADR_CTRL)
            dat_d[`FFR_B_DOUBLE] = ctrl_q;
      end
      if (wr)
      begin
         if (wb_adr_i == `FFR_ADR_FLAG)
            w1c = w1c_m[`FFR_NFLAG-1:0];
         else if (wb_adr_i == `FFR_ADR_MASK)
            mask_d = mask_m[`FFR_NFLAG-1:0];
         else if (wb_adr_i == `FFR_ADR_CTRL)
            ctrl_d = ctrl_m[`FFR_B_DOUBLE];
      end
   end

   // sticky flags: a set in the clearing cycle wins
   always_comb
   begin
      flag_d = (flag_q & ~w1c) | ev;
      // timer flag follows the latch only
      flag_d[`FFR_B_TMR] = tfault_d;
   end

   // register bus state
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_q <= 1'b0;
         dat_q <= '0;
         mask_q <= `FFR_MASK_RST;
         ctrl_q <= `FFR_CTRL_RST;
         flag_q <= `FFR_FLAG_RST;
      end
      else
      begin
         ack_q <= ack_d;
         dat_q <= dat_d;
         mask_q <= mask_d;
         ctrl_q <= ctrl_d;
         flag_q <= flag_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
   assign irq_o = |(flag_q & ~mask_q);

   // ****************************************
   // interrupt pulse
   // ****************************************
   // mask sampled at the event, so a late unmask stays silent
   assign start = |(ev & ~mask_q);

   // retrigger reloads the full width
   always_comb
   begin
      icnt_d = icnt_q;
      ioe_d = ioe_q;
      if (start)
      begin
         ioe_d = 1'b1;
         icnt_d = 16'(P_INT_PULSE_CYC - 1);
      end
      else if (ioe_q)
      begin
         if (icnt_q == 16'h0)
            ioe_d = 1'b0;
         else
            icnt_d = icnt_q - 16'h1;
      end
   end

   // register pulse state
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         icnt_q <= '0;
         ioe_q <= 1'b0;
      end
      else
      begin
         icnt_q <= icnt_d;
         ioe_q <= ioe_d;
      end
   end

   // open drain: only ever pulls low
   assign int_n_o = 1'b0;
   assign int_oe_o = ioe_q;

   // ****************************************
   // charger, timer and rail response
   // ****************************************
   // uvlo, adc and watchdog deliberately steer nothing here
   always_comb
   begin
      chg_en_d = input_power_good_status_i & charge_enable_i & ~tfault_d
                 & ~cond[`FFR_B_OCP];
      paused_d = input_overvoltage_i | therm_cold_i | therm_hot_i | therm_open_i;
      tpause_d = therm_cold_i | therm_hot_i | therm_open_i;
      cur_red_d = therm_cool_i;
      tdbl_d = therm_cool_i & ctrl_q;
      vreg_red_d = therm_warm_i;
      trst_d = ev[`FFR_B_PGOOD] | ev[`FFR_B_OVP] | (tfault_q & ~tfault_d);
      rail_bat_d = input_overvoltage_i;
      bat_disc_d = cond[`FFR_B_OCP];
   end

   // register response outputs
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         chg_en_q <= 1'b0;
         paused_q <= 1'b0;
         cur_red_q <= 1'b0;
         vreg_red_q <= 1'b0;
         trst_q <= 1'b0;
         tpause_q <= 1'b0;
         tdbl_q <= 1'b0;
         rail_bat_q <= 1'b0;
         bat_disc_q <= 1'b0;
      end
      else
      begin
         chg_en_q <= chg_en_d;
         paused_q <= paused_d;
         cur_red_q <= cur_red_d;
         vreg_red_q <= vreg_red_d;
         trst_q <= trst_d;
         tpause_q <= tpause_d;
         tdbl_q <= tdbl_d;
         rail_bat_q <= rail_bat_d;
         bat_disc_q <= bat_disc_d;
      end
   end

   assign charge_enable_o = chg_en_q;
   assign charge_paused_o = paused_q;
   assign charge_current_reduced_o = cur_red_q;
   assign reg_voltage_reduced_o = vreg_red_q;
   assign timer_reset_o = trst_q;
   assign timer_pause_o = tpause_q;
   assign timer_double_o = tdbl_q;
   assign system_rail_from_battery_o = rail_bat_q;
   assign battery_disconnect_o = bat_disc_q;

   // ****************************************
   // checks
   // ****************************************
   property p_pgood_off;
      @(posedge clk_i) disable iff (rst_i)
      !input_power_good_status_i |=> !charge_enable_o;
   endproperty
   a_pgood_off: assert property (p_pgood_off)
      else $error("charging on without power good");

   property p_pgood_edge;
      @(posedge clk_i) disable iff (rst_i)
      $fell(input_power_good_status_i) |=> flag_q[`FFR_B_PGOOD] && timer_reset_o;
   endproperty
   a_pgood_edge: assert property (p_pgood_edge)
      else $error("power good fall not flagged");

   property p_ovp;
      @(posedge clk_i) disable iff (rst_i)
      input_overvoltage_i |=> charge_paused_o && system_rail_from_battery_o;
   endproperty
   a_ovp: assert property (p_ovp)
      else $error("overvoltage response missing");

   property p_ocp;
      @(posedge clk_i) disable iff (rst_i)
      bat_overcurrent_i && bat_only_i |=> battery_disconnect_o && !charge_enable_o;
   endproperty
   a_ocp: assert property (p_ocp)
      else $error("overcurrent response missing");

   property p_therm_pause;
      @(posedge clk_i) disable iff (rst_i)
      therm_cold_i || therm_hot_i || therm_open_i |=> charge_paused_o && timer_pause_o;
   endproperty
   a_therm_pause: assert property (p_therm_pause)
      else $error("thermistor pause missing");

   property p_cool;
      @(posedge clk_i) disable iff (rst_i)
      therm_cool_i |=> charge_current_reduced_o && (timer_double_o == $past(ctrl_q));
   endproperty
   a_cool: assert property (p_cool)
      else $error("cool response wrong");

   property p_tfault;
      @(posedge clk_i) disable iff (rst_i)
      charge_timer_expired_i |=> flag_q[`FFR_B_TMR] && !charge_enable_o;
   endproperty
   a_tfault: assert property (p_tfault)
      else $error("timer fault not latched");

   property p_int_load;
      @(posedge clk_i) disable iff (rst_i)
      start |=> int_oe_o && icnt_q == 16'(P_INT_PULSE_CYC - 1);
   endproperty
   a_int_load: assert property (p_int_load)
      else $error("interrupt pulse not started");

   property p_int_quiet;
      @(posedge clk_i) disable iff (rst_i)
      !int_oe_o && !start |=> !int_oe_o;
   endproperty
   a_int_quiet: assert property (p_int_quiet)
      else $error("interrupt pulse without unmasked event");

endmodule

// ===== verif/ffr_host_model.sv
/*
 host model: classic wishbone master that reaches the flag registers.
 assumes a slave that answers within twenty cycles of the request.
*/
`timescale 1ns/1ps
module ffr_host_model
(
   input wire logic clk_i, // system clock
   output logic cyc_o, // bus cycle
   output logic stb_o, // strobe
   output logic we_o, // write
   output logic [7:0] adr_o, // byte address
   output logic [3:0] sel_o, // byte lanes
   output logic [31:0] dat_o, // write data
   input wire logic [31:0] dat_i, // read data
   input wire logic ack_i // acknowledge
);
   // ****************************************
   // bus idle at time zero
   // ****************************************
   initial
   begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o = 1'b0;
      adr_o = 8'h00;
      sel_o = 4'h0;
      dat_o = 32'h0000_0000;
   end

   // one transfer; gap idles first so the slave sees slow hosts too
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s, input int gap, output logic [31:0] q, output logic ok);
      int n;
      repeat (gap) @(posedge clk_i);
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= w;
      adr_o <= a;
      sel_o <= s;
      dat_o <= d;
      ok = 1'b0;
      q = 32'h0000_0000;
      for (n = 0; n < 20 && !ok; n++)
      begin
         @(posedge clk_i);
         if (ack_i === 1'b1)
         begin
            ok = 1'b1;
            q = dat_i;
         end
      end
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      // released data no longer shows the last value
      dat_o <= ~d;
   endtask
endmodule

// ===== verif/ffr_top_test.sv
/*
 bench for the fault flag response block: drives conditions, checks flags.
 assumes ffr_host_model as bus master and shortened hold counts.
*/
`timescale 1ns/1ps
`include "ffr_map.svh"
module ffr_top_test;
   localparam int PULSE = 4;
   localparam int W1 = 10;
   localparam int W2 = 20;
   localparam int WN = 40;
   logic clk_i, rst_i, cyc, stb, we, ack, irq, int_n, int_oe;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, q, d0, d1;
   logic pg, ovp, ocp, bonly, uvlo, cold, cool, warm, hot, opn, adc, wd, tmr, cen, btn_n;
   logic en_o, pause_o, cur_o, regv_o, trst_o, tpause_o, tdbl_o, rail_o, disc_o;
   logic [15:0] lfsr_q;
   int miscompares, cmp_count, k;

   ffr_top #(.P_INT_PULSE_CYC(PULSE), .P_WAKE1_CYC(W1), .P_WAKE2_CYC(W2), .P_WARN_CYC(WN)) dut
   (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .irq_o(irq), .input_power_good_status_i(pg), .input_overvoltage_i(ovp),
      .bat_overcurrent_i(ocp), .bat_only_i(bonly), .bat_undervoltage_i(uvlo),
      .therm_cold_i(cold), .therm_cool_i(cool), .therm_warm_i(warm), .therm_hot_i(hot),
      .therm_open_i(opn), .adc_done_i(adc), .bus_watchdog_expired_i(wd),
      .charge_timer_expired_i(tmr), .charge_enable_i(cen), .push_button_input_n_i(btn_n),
      .charge_enable_o(en_o), .charge_paused_o(pause_o), .charge_current_reduced_o(cur_o),
      .reg_voltage_reduced_o(regv_o), .timer_reset_o(trst_o), .timer_pause_o(tpause_o),
      .timer_double_o(tdbl_o), .system_rail_from_battery_o(rail_o),
      .battery_disconnect_o(disc_o), .int_n_o(int_n), .int_oe_o(int_oe)
   );

   ffr_host_model u_host
   (
      .clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
      .dat_o(wdat), .dat_i(rdat), .ack_i(ack)
   );

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [15:0] nxt(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // {enable, paused, current cut, vreg cut, timer hold, timer double, rail, disconnect}
   function automatic logic [7:0] exp_resp(input int i);
      case (i)
         1: return 8'hc2;
         2: return 8'h01;
         4, 7, 8: return 8'hc8;
         5: return 8'ha4;
         6: return 8'h90;
         default: return 8'h80;
      endcase
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // a bus hang counts as a mismatch and ends the run
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      logic ok;
      lfsr_q = nxt(lfsr_q);
      u_host.xfer(w, a, d, s, lfsr_q[1:0], q, ok);
      if (!ok)
      begin
         miscompares++;
         end_of_test();
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000, 4'hf);
      chk(q, e);
   endtask

   task automatic set_cond(input int i, input logic v);
      case (i)
         0: pg <= v;
         1: ovp <= v;
         2: ocp <= v;
         3: uvlo <= v;
         4: cold <= v;
         5: cool <= v;
         6: warm <= v;
         7: hot <= v;
         8: opn <= v;
         9: adc <= v;
         default: wd <= v;
      endcase
   endtask

   // one condition: response, pulse length, flag, status, clear, falling edge
   task automatic cond_case(input int i);
      set_cond(i, 1'b1);
      @(posedge clk_i);
      if (i >= 9)
         set_cond(i, 1'b0);
      #1;
      chk({en_o, pause_o, cur_o, regv_o, tpause_o, tdbl_o, rail_o, disc_o}, exp_resp(i));
      chk(trst_o, i < 2);
      chk({int_oe, irq, int_n}, 3'b110);
      repeat (PULSE - 1) @(posedge clk_i);
      #1;
      chk(int_oe, 1'b1);
      @(posedge clk_i);
      #1;
      chk(int_oe, 1'b0);
      rd(`FFR_ADR_FLAG, 32'h1 << i);
      if (i < 9)
         rd(`FFR_ADR_STAT, (32'h1 << i) | 32'h1);
      bus(1'b1, `FFR_ADR_FLAG, 32'h1 << i, 4'hf);
      rd(`FFR_ADR_FLAG, 32'h0);
      if (i > 0 && i < 9)
      begin
         set_cond(i, 1'b0);
         repeat (2) @(posedge clk_i);
         rd(`FFR_ADR_FLAG, 32'h0);
      end
   endtask

   // ****************************************
   // clock and main sequence
   // ****************************************
   initial
   begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   initial
   begin
      rst_i = 1'b1;
      {pg, ovp, ocp, uvlo, cold, cool, warm, hot, opn, adc, wd, tmr} = 12'h000;
      bonly = 1'b1;
      cen = 1'b1;
      btn_n = 1'b1;
      miscompares = 0;
      cmp_count = 0;
      lfsr_q = 16'h089e;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      // reset values, read-only status, unmapped place
      rd(`FFR_ADR_MASK, 32'h0);
      rd(`FFR_ADR_CTRL, 32'h0);
      bus(1'b1, `FFR_ADR_STAT, 32'hffff_ffff, 4'hf);
      rd(`FFR_ADR_STAT, 32'h0);
      bus(1'b1, 8'h10, 32'hffff_ffff, 4'hf);
      rd(8'h10, 32'h0);
      // random mask values written one byte lane at a time
      for (k = 0; k < 6; k++)
      begin
         lfsr_q = nxt(lfsr_q);
         d0 = {16'h0000, lfsr_q};
         bus(1'b1, `FFR_ADR_MASK, d0, 4'h1);
         lfsr_q = nxt(lfsr_q);
         // keep the written word: the bus task steps the lfsr for its gap
         d1 = {16'h0000, lfsr_q};
         bus(1'b1, `FFR_ADR_MASK, d1, 4'h2);
         rd(`FFR_ADR_MASK, {17'h0, d1[14:8], d0[7:0]});
      end
      bus(1'b1, `FFR_ADR_MASK, 32'h0, 4'hf);
      bus(1'b1, `FFR_ADR_CTRL, 32'h1, 4'hf);
      rd(`FFR_ADR_CTRL, 32'h1);
      for (k = 0; k < 11; k++)
         cond_case(k);
      // masked event never pulses, even once unmasked
      bus(1'b1, `FFR_ADR_MASK, 32'h0000_7fff, 4'hf);
      set_cond(4, 1'b1);
      for (k = 0; k < 8; k++)
      begin
         @(posedge clk_i);
         #1;
         chk({int_oe, irq}, 2'b00);
      end
      rd(`FFR_ADR_FLAG, 32'h10);
      bus(1'b1, `FFR_ADR_MASK, 32'h0, 4'hf);
      for (k = 0; k < 8; k++)
      begin
         @(posedge clk_i);
         #1;
         chk({int_oe, irq}, 2'b01);
      end
      bus(1'b1, `FFR_ADR_FLAG, 32'h10, 4'hf);
      set_cond(4, 1'b0);
      // timer fault latches until the enable toggles
      tmr <= 1'b1;
      @(posedge clk_i);
      tmr <= 1'b0;
      #1;
      chk(en_o, 1'b0);
      bus(1'b1, `FFR_ADR_FLAG, 32'h800, 4'hf);
      rd(`FFR_ADR_FLAG, 32'h800);
      cen <= 1'b0;
      @(posedge clk_i);
      cen <= 1'b1;
      for (k = 0; k < 6; k++)
      begin
         @(posedge clk_i);
         #1;
         if (trst_o === 1'b1)
            break;
      end
      chk(trst_o, 1'b1);
      rd(`FFR_ADR_FLAG, 32'h0);
      chk(en_o, 1'b1);
      // hold thresholds, margins allow for bus gaps
      btn_n <= 1'b0;
      repeat (W1 + 4) @(posedge clk_i);
      rd(`FFR_ADR_FLAG, 32'h1000);
      repeat (12) @(posedge clk_i);
      rd(`FFR_ADR_FLAG, 32'h3000);
      repeat (20) @(posedge clk_i);
      rd(`FFR_ADR_FLAG, 32'h7000);
      btn_n <= 1'b1;
      // mid-run reset clears mask, control and flags; power good still high
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(`FFR_ADR_CTRL, 32'h0);
      rd(`FFR_ADR_FLAG, 32'h1);
      bus(1'b1, `FFR_ADR_FLAG, 32'h1, 4'hf);
      // doubling stays off while the option is clear
      cool <= 1'b1;
      @(posedge clk_i);
      #1;
      chk({cur_o, tdbl_o}, 2'b10);
      bus(1'b1, `FFR_ADR_FLAG, 32'h20, 4'hf);
      cool <= 1'b0;
      // power-good fall: charging off, timer reset, flag set
      pg <= 1'b0;
      @(posedge clk_i);
      #1;
      chk({en_o, trst_o}, 2'b01);
      rd(`FFR_ADR_FLAG, 32'h1);
      end_of_test();
   end
endmodule
